// file: excitation_class_pkg.sv
package excitation_class_pkg;

  // ----------------------------------------------------------------
  // Widths and window lengths
  // ----------------------------------------------------------------
  localparam int ENERGY_W     = 16;  // Frame energy, signed Q8.8 dB
  localparam int DELTA_W      = 17;
  localparam int SUM_W        = 24;
  localparam int ACC_W        = 40;
  localparam int ROOT_W       = 32;
  localparam int SIGMA_W      = 16;
  localparam int HIST_LEN     = 40;
  localparam int DEV_LEN      = 15;
  localparam int ROOT_STEPS   = 16;
  localparam int CAT_W        = 3;
  localparam int NUM_THR      = 4;
  localparam int RED_W        = 4;
  localparam int FREQ_W       = 13;

  // ----------------------------------------------------------------
  // Scaling and counting constants
  // ----------------------------------------------------------------
  localparam logic [7:0]        SCALE_P      = 8'hC5;  // 0.77 in Q0.8
  localparam int                SCALE_SHIFT  = 8;
  localparam logic [ROOT_W-1:0] ROOT_ONE     = 32'h4000_0000;
  localparam logic [5:0]        RUN_LIMIT    = 6'h1E;  // 30 frames
  localparam logic [1:0]        ERASE_FRAMES = 2'h3;

  // ----------------------------------------------------------------
  // Threshold defaults, Q8.8, packed {thr4, thr3, thr2, thr1}
  // ----------------------------------------------------------------
  localparam logic [63:0] THR_INIT_DEF = 64'h0100_0180_0200_0300;
  localparam logic [63:0] THR_MIN_DEF  = 64'h0080_00C0_0100_0180;
  localparam logic [63:0] THR_MAX_DEF  = 64'h0200_0300_0400_0600;
  localparam logic [15:0] THR_STEP_DEF = 16'h0010;

  // ----------------------------------------------------------------
  // Category codes and their noise reducer settings
  // ----------------------------------------------------------------
  typedef logic [CAT_W-1:0] sound_category_t;
  localparam sound_category_t CAT_NONTONAL = 3'h0;
  localparam sound_category_t CAT_TONAL3   = 3'h3;
  localparam sound_category_t CAT_MAX      = 3'h4;

  localparam logic [RED_W-1:0]  RED_CAT0_DB  = 4'h0;
  localparam logic [RED_W-1:0]  RED_CAT1_DB  = 4'h6;
  localparam logic [RED_W-1:0]  RED_CAT2_DB  = 4'h9;
  localparam logic [RED_W-1:0]  RED_CAT34_DB = 4'hC;
  localparam logic [FREQ_W-1:0] FREQ_NONE_HZ = 13'h000;
  localparam logic [FREQ_W-1:0] FREQ_510_HZ  = 13'h1FE;
  localparam logic [FREQ_W-1:0] FREQ_400_HZ  = 13'h190;
  localparam logic [FREQ_W-1:0] FREQ_300_HZ  = 13'h12C;

  // Cycles from frame_tick to result_valid
  localparam int RESULT_LATENCY = 34;

endpackage

// file: stats_if.sv
`timescale 1ns/10ps
interface stats_if;
  import excitation_class_pkg::*;
  logic                          start;
  logic signed [ENERGY_W-1:0]    energy;
  logic                          done;
  logic        [SIGMA_W-1:0]     sigma;

  modport ctrl   (output start, output energy, input done, input sigma);
  modport engine (input start, input energy, output done, output sigma);
endinterface

// file: deviation_engine.sv
`timescale 1ns/10ps
module deviation_engine #(
  parameter int HIST_DEPTH = excitation_class_pkg::HIST_LEN,
  parameter int DEV_DEPTH  = excitation_class_pkg::DEV_LEN
) (
  input  wire logic   sys_clk,
  input  wire logic   resetn,
  stats_if.engine     st
);
  import excitation_class_pkg::*;

  typedef enum logic [3:0] {
    ENG_IDLE  = 4'h1,
    ENG_ACC   = 4'h2,
    ENG_ROOT  = 4'h4,
    ENG_SCALE = 4'h8
  } eng_state_t;

  eng_state_t                 state;
  logic signed [DELTA_W-1:0]  hist [HIST_DEPTH];
  logic        [5:0]          wr_ptr;
  logic        [5:0]          rd_ptr;
  logic        [4:0]          k;
  logic                       have_prev;
  logic signed [ENERGY_W-1:0] prev_energy;
  logic signed [SUM_W-1:0]    sum;
  logic signed [DELTA_W-1:0]  mean;
  logic signed [DELTA_W-1:0]  delta;
  logic signed [DELTA_W:0]    diff;
  logic        [ACC_W-1:0]    acc;
  logic        [ACC_W-1:0]    next_acc;
  logic        [ACC_W-1:0]    ms_wide;
  logic        [ROOT_W-1:0]   op;
  logic        [ROOT_W-1:0]   res;
  logic        [ROOT_W-1:0]   one;
  logic        [SIGMA_W+7:0]  scaled;

  // ----------------------------------------------------------------
  // Energy change and running sums
  // ----------------------------------------------------------------
  assign delta    = have_prev ? DELTA_W'(st.energy) - DELTA_W'(prev_energy) : '0;
  assign mean     = DELTA_W'(sum / SUM_W'(HIST_DEPTH));
  assign diff     = (DELTA_W+1)'(hist[rd_ptr]) - (DELTA_W+1)'(mean);
  // Widen before squaring: a change of 2 dB or more would wrap an 18-bit product
  assign next_acc = acc + $unsigned(ACC_W'(diff) * ACC_W'(diff));
  assign ms_wide  = next_acc / ACC_W'(DEV_DEPTH);
  assign scaled   = res[SIGMA_W-1:0] * SCALE_P;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist[i] <= '0;
      end
      wr_ptr      <= '0;
      sum         <= '0;
      have_prev   <= 1'b0;
      prev_energy <= '0;
    end else if (state == ENG_IDLE && st.start) begin
      // Running sum avoids re-adding 40 entries each frame
      hist[wr_ptr] <= delta;
      sum          <= sum + SUM_W'(delta) - SUM_W'(hist[wr_ptr]);
      wr_ptr       <= (wr_ptr == 6'(HIST_DEPTH - 1)) ? '0 : wr_ptr + 6'h01;
      have_prev    <= 1'b1;
      prev_energy  <= st.energy;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: deviation sum, square root, scaling
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state    <= ENG_IDLE;
      rd_ptr   <= '0;
      k        <= '0;
      acc      <= '0;
      op       <= '0;
      res      <= '0;
      one      <= '0;
      st.done  <= 1'b0;
      st.sigma <= '0;
    end else begin
      st.done <= 1'b0;
      case (state)
        ENG_IDLE: begin
          if (st.start) begin
            rd_ptr <= wr_ptr;
            k      <= '0;
            acc    <= '0;
            state  <= ENG_ACC;
          end
        end
        ENG_ACC: begin
          acc    <= next_acc;
          rd_ptr <= (rd_ptr == 6'h00) ? 6'(HIST_DEPTH - 1) : rd_ptr - 6'h01;
          k      <= k + 5'h01;
          if (k == 5'(DEV_DEPTH - 1)) begin
            op    <= (ms_wide > ACC_W'({ROOT_W{1'b1}})) ? '1 : ms_wide[ROOT_W-1:0];
            res   <= '0;
            one   <= ROOT_ONE;
            k     <= '0;
            state <= ENG_ROOT;
          end
        end
        ENG_ROOT: begin
          if (op >= res + one) begin
            op  <= op - (res + one);
            res <= (res >> 1) + one;
          end else begin
            res <= res >> 1;
          end
          one <= one >> 2;
          k   <= k + 5'h01;
          if (k == 5'(ROOT_STEPS - 1)) begin
            state <= ENG_SCALE;
          end
        end
        ENG_SCALE: begin
          st.sigma <= scaled[SIGMA_W+SCALE_SHIFT-1:SCALE_SHIFT];
          st.done  <= 1'b1;
          state    <= ENG_IDLE;
        end
        default: state <= ENG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_sum_update;
    @(posedge sys_clk) disable iff (!resetn)
    (state == ENG_IDLE && st.start) |=> (sum == $past(sum) + SUM_W'($past(delta)) - SUM_W'($past(hist[wr_ptr])));
  endproperty
  a_sum_update: assert property (p_sum_update) else $error("running energy change sum wrong");

  property p_done_timing;
    @(posedge sys_clk) disable iff (!resetn)
    (state == ENG_IDLE && st.start) |-> ##33 st.done;
  endproperty
  a_done_timing: assert property (p_done_timing) else $error("deviation not ready on time");

endmodule

// file: excitation_tonality_classifier.sv
`timescale 1ns/10ps
module excitation_tonality_classifier #(
  parameter logic [63:0] THR_INIT = excitation_class_pkg::THR_INIT_DEF,
  parameter logic [63:0] THR_MIN  = excitation_class_pkg::THR_MIN_DEF,
  parameter logic [63:0] THR_MAX  = excitation_class_pkg::THR_MAX_DEF,
  parameter logic [15:0] THR_STEP = excitation_class_pkg::THR_STEP_DEF
) (
  input  wire logic                                                sys_clk,
  input  wire logic                                                resetn,
  input  wire logic                                                frame_tick,
  input  wire logic signed [excitation_class_pkg::ENERGY_W-1:0]    frame_energy,
  input  wire logic                                                frame_erased,
  input  wire logic                                                vad_present,
  input  wire logic                                                vad_active,
  input  wire logic                                                prev_generic,
  output      excitation_class_pkg::sound_category_t               sound_category,
  output      logic        [excitation_class_pkg::RED_W-1:0]       max_reduction_db,
  output      logic        [excitation_class_pkg::FREQ_W-1:0]      start_freq_hz,
  output      logic                                                result_valid
);
  import excitation_class_pkg::*;

  stats_if st ();

  logic [15:0]     thr [NUM_THR];
  logic [1:0]      erase_left;
  logic            force_zero;
  logic            erase_now;
  logic [5:0]      tonal_run;
  logic [5:0]      quiet_run;
  logic            raise;
  logic            lower;
  sound_category_t prev_cat;
  sound_category_t cand;
  sound_category_t next_cat;

  // ----------------------------------------------------------------
  // Statistics engine
  // ----------------------------------------------------------------
  // Frame energy arrives already in dB form from the spectral stage
  assign st.start  = frame_tick;
  assign st.energy = frame_energy;

  deviation_engine u_engine (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .st      (st.engine)
  );

  // ----------------------------------------------------------------
  // Forcing conditions, caught at the frame tick
  // ----------------------------------------------------------------
  assign erase_now = frame_tick && frame_erased;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      erase_left <= '0;
      force_zero <= 1'b0;
    end else if (frame_tick) begin
      // The erased frame itself counts as the first of the run
      if (frame_erased) begin
        erase_left <= ERASE_FRAMES - 2'h1;
      end else if (erase_left != 2'h0) begin
        erase_left <= erase_left - 2'h1;
      end
      force_zero <= frame_erased || (erase_left != 2'h0)
                 || (vad_present && !vad_active) || !prev_generic;
    end
  end

  // ----------------------------------------------------------------
  // Category decision
  // ----------------------------------------------------------------
  always_comb begin
    cand = CAT_NONTONAL;
    // Ascending scan: the last hit is the highest qualifying category
    for (int c = 1; c <= NUM_THR; c++) begin
      if (st.sigma < thr[c-1] && prev_cat >= CAT_W'(c - 1)) begin
        cand = CAT_W'(c);
      end
    end
  end

  assign next_cat = force_zero ? CAT_NONTONAL : cand;
  assign raise    = st.done && next_cat >= CAT_TONAL3 && tonal_run == RUN_LIMIT;
  assign lower    = st.done && next_cat == CAT_NONTONAL && quiet_run == RUN_LIMIT;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sound_category   <= CAT_NONTONAL;
      prev_cat         <= CAT_NONTONAL;
      max_reduction_db <= RED_CAT0_DB;
      start_freq_hz    <= FREQ_NONE_HZ;
      result_valid     <= 1'b0;
    end else begin
      result_valid <= st.done;
      if (st.done) begin
        sound_category <= next_cat;
        prev_cat       <= next_cat;
        case (next_cat)
          3'h1: begin
            max_reduction_db <= RED_CAT1_DB;
            start_freq_hz    <= FREQ_510_HZ;
          end
          3'h2: begin
            max_reduction_db <= RED_CAT2_DB;
            start_freq_hz    <= FREQ_510_HZ;
          end
          3'h3: begin
            max_reduction_db <= RED_CAT34_DB;
            start_freq_hz    <= FREQ_400_HZ;
          end
          3'h4: begin
            max_reduction_db <= RED_CAT34_DB;
            start_freq_hz    <= FREQ_300_HZ;
          end
          default: begin
            max_reduction_db <= RED_CAT0_DB;
            start_freq_hz    <= FREQ_NONE_HZ;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Run counters
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tonal_run <= '0;
      quiet_run <= '0;
    end else if (st.done) begin
      if (next_cat >= CAT_TONAL3 && !raise) begin
        tonal_run <= tonal_run + 6'h01;
      end else begin
        tonal_run <= '0;
      end
      if (next_cat == CAT_NONTONAL && !lower) begin
        quiet_run <= quiet_run + 6'h01;
      end else begin
        quiet_run <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Floating thresholds
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_THR; i++) begin : g_thr
      localparam logic [15:0] T_INIT = THR_INIT[16*i +: 16];
      localparam logic [15:0] T_MIN  = THR_MIN[16*i +: 16];
      localparam logic [15:0] T_MAX  = THR_MAX[16*i +: 16];
      logic [16:0] up;
      assign up = {1'b0, thr[i]} + {1'b0, THR_STEP};

      // Erasure wins over any step taken in the same cycle
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          thr[i] <= T_INIT;
        end else if (erase_now) begin
          thr[i] <= T_MIN;
        end else if (raise) begin
          thr[i] <= (up > {1'b0, T_MAX}) ? T_MAX : up[15:0];
        end else if (lower) begin
          thr[i] <= (thr[i] < T_MIN + THR_STEP) ? T_MIN : thr[i] - THR_STEP;
        end
      end

      property p_thr_bounds;
        @(posedge sys_clk) disable iff (!resetn)
        (thr[i] >= T_MIN) && (thr[i] <= T_MAX);
      endproperty
      a_thr_bounds: assert property (p_thr_bounds) else $error("threshold out of bounds");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cat_range;
    @(posedge sys_clk) disable iff (!resetn)
    result_valid |-> sound_category <= CAT_MAX;
  endproperty
  a_cat_range: assert property (p_cat_range) else $error("category out of range");

  property p_cat0_setting;
    @(posedge sys_clk) disable iff (!resetn)
    (result_valid && sound_category == 3'h0) |-> (max_reduction_db == 4'h0 && start_freq_hz == 13'h000);
  endproperty
  a_cat0_setting: assert property (p_cat0_setting) else $error("category 0 must allow no reduction");

  property p_tonal_setting;
    @(posedge sys_clk) disable iff (!resetn)
    (result_valid && sound_category == 3'h4) |-> (max_reduction_db == 4'hC && start_freq_hz == 13'h12C);
  endproperty
  a_tonal_setting: assert property (p_tonal_setting) else $error("category 4 settings wrong");

  property p_latency;
    @(posedge sys_clk) disable iff (!resetn)
    frame_tick |-> ##34 result_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("result not delivered on time");

  property p_erase_min;
    @(posedge sys_clk) disable iff (!resetn)
    erase_now |=> (thr[0] == THR_MIN[15:0] && thr[3] == THR_MIN[63:48]);
  endproperty
  a_erase_min: assert property (p_erase_min) else $error("erasure did not reset thresholds");

  property p_erase_zero;
    @(posedge sys_clk) disable iff (!resetn)
    erase_now |-> ##34 (result_valid && sound_category == 3'h0);
  endproperty
  a_erase_zero: assert property (p_erase_zero) else $error("erased frame not category 0");

  property p_vad_zero;
    @(posedge sys_clk) disable iff (!resetn)
    (frame_tick && vad_present && !vad_active) |-> ##34 (sound_category == 3'h0);
  endproperty
  a_vad_zero: assert property (p_vad_zero) else $error("silence not forced to category 0");

  property p_raise_clears;
    @(posedge sys_clk) disable iff (!resetn)
    raise |=> (tonal_run == 6'h00 && thr[1] >= $past(thr[1]));
  endproperty
  a_raise_clears: assert property (p_raise_clears) else $error("raise did not restart run");

  property p_step_up;
    @(posedge sys_clk) disable iff (!resetn)
    (st.done && next_cat == 3'h2 && prev_cat < 3'h1) |-> 1'b0;
  endproperty
  a_step_up: assert property (p_step_up) else $error("category 2 without prior category 1");

endmodule

// file: frame_source.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Frame stimulus standing in for the spectral analysis stage in front of the classifier
// ----------------------------------------------------------------
module frame_source
  import excitation_class_pkg::*;
(
  input  wire logic                                             sys_clk,
  input  wire logic                                             result_valid,
  output      logic                                             frame_tick,
  output      logic signed [excitation_class_pkg::ENERGY_W-1:0] frame_energy,
  output      logic                                             frame_erased,
  output      logic                                             vad_present,
  output      logic                                             vad_active,
  output      logic                                             prev_generic
);
  import excitation_class_pkg::*;

  initial begin
    {frame_tick, frame_energy, frame_erased, vad_present, vad_active, prev_generic} = '0;
  end

  // One frame: energy in Q8.8 dB, then lines inverted so stale values never look valid
  task automatic send(input logic signed [ENERGY_W-1:0] e, input logic er, input logic vp,
                      input logic va, input logic pg, output int lat, output logic wide);
    @(posedge sys_clk);
    {frame_tick, frame_energy, frame_erased, vad_present, vad_active, prev_generic} <= {1'b1, e, er, vp, va, pg};
    @(posedge sys_clk);
    {frame_tick, frame_energy, frame_erased, vad_present, vad_active, prev_generic} <= {1'b0, ~e, ~er, ~vp, ~va, ~pg};
    lat = 1;
    while (result_valid !== 1'b1 && lat < 100) begin
      @(posedge sys_clk);
      lat++;
    end
    @(posedge sys_clk);
    wide = result_valid;
  endtask
endmodule

// file: excitation_tonality_classifier_tb.sv
`timescale 1ns/10ps
module excitation_tonality_classifier_tb;
  import excitation_class_pkg::*;

  logic                       sys_clk;
  logic                       resetn;
  logic                       frame_tick;
  logic signed [ENERGY_W-1:0] frame_energy;
  logic                       frame_erased;
  logic                       vad_present;
  logic                       vad_active;
  logic                       prev_generic;
  sound_category_t            sound_category;
  logic        [RED_W-1:0]    max_reduction_db;
  logic        [FREQ_W-1:0]   start_freq_hz;
  logic                       result_valid;
  int                         n_errors;
  int                         checked;
  int                         seed;
  int                         lat;
  int                         erase_left;
  int                         tonal_n;
  int                         quiet_n;
  logic        [15:0]         thr1;
  logic                       wide;
  logic                       er;
  logic                       vp;
  logic                       va;
  logic                       pg;
  logic        [31:0]         r;
  logic signed [ENERGY_W-1:0] e0;
  sound_category_t            prev;
  sound_category_t            want;

  excitation_tonality_classifier u_dut (.sys_clk(sys_clk), .resetn(resetn), .frame_tick(frame_tick),
    .frame_energy(frame_energy), .frame_erased(frame_erased), .vad_present(vad_present),
    .vad_active(vad_active), .prev_generic(prev_generic), .sound_category(sound_category),
    .max_reduction_db(max_reduction_db), .start_freq_hz(start_freq_hz), .result_valid(result_valid));

  frame_source u_src (.sys_clk(sys_clk), .result_valid(result_valid), .frame_tick(frame_tick),
    .frame_energy(frame_energy), .frame_erased(frame_erased), .vad_present(vad_present),
    .vad_active(vad_active), .prev_generic(prev_generic));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [15:0] red_of(input sound_category_t c);
    case (c)
      3'h1: return 16'h0006;
      3'h2: return 16'h0009;
      3'h3, 3'h4: return 16'h000C;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] freq_of(input sound_category_t c);
    case (c)
      3'h1, 3'h2: return 16'h01FE;
      3'h3: return 16'h0190;
      3'h4: return 16'h012C;
      default: return 16'h0000;
    endcase
  endfunction

  // Calm frames have zero deviation, so every threshold is met and only history decides
  task automatic frame(input logic signed [ENERGY_W-1:0] e, input logic calm, input logic chk);
    u_src.send(e, er, vp, va, pg, lat, wide);
    check(16'(lat), 16'(RESULT_LATENCY + 1));
    check({15'h0, wide}, 16'h0000);
    if (er) begin
      erase_left = 3;
      thr1 = THR_MIN_DEF[15:0];
    end
    want = (erase_left > 0 || (vp && !va) || !pg || !calm) ? 3'h0 : (prev == 3'h4 ? 3'h4 : prev + 3'h1);
    if (erase_left > 0)
      erase_left--;
    prev = want;
    // Runs of 31 frames step the thresholds, then the run starts over
    tonal_n = (want >= 3'h3) ? tonal_n + 1 : 0;
    quiet_n = (want == 3'h0) ? quiet_n + 1 : 0;
    if (tonal_n > 30) begin
      tonal_n = 0;
      thr1 = (thr1 + THR_STEP_DEF > THR_MAX_DEF[15:0]) ? THR_MAX_DEF[15:0] : thr1 + THR_STEP_DEF;
    end
    if (quiet_n > 30) begin
      quiet_n = 0;
      thr1 = (thr1 > THR_MIN_DEF[15:0] + THR_STEP_DEF) ? thr1 - THR_STEP_DEF : THR_MIN_DEF[15:0];
    end
    check(u_dut.thr[0], thr1);
    if (chk) begin
      if (calm)
        check({13'h0, sound_category}, {13'h0, want});
      else
        check({13'h0, sound_category}, 16'h0000);
      check({12'h0, max_reduction_db}, red_of(want));
      check({3'h0, start_freq_hz}, freq_of(want));
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    test_done;
  end

  initial begin
    seed = 32'hd4d6ce81;
    resetn = 1'b0;
    {n_errors, checked, erase_left, tonal_n, quiet_n} = '0;
    thr1 = THR_INIT_DEF[15:0];
    prev = 3'h0;
    {er, vp, va, pg} = 4'b0011;
    repeat (4) @(posedge sys_clk);
    check({8'h00, sound_category, max_reduction_db, result_valid}, 16'h0000);
    check({3'h0, start_freq_hz}, 16'h0000);
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    e0 = 16'($random(seed)) & 16'h0FFF;
    // Frames 17 to 60 stay unforced so a long tonal run raises the thresholds
    for (int i = 0; i < 100; i++) begin
      r = $random(seed);
      er = (i == 6) || (i > 60 && r[3:0] == 4'h0);
      vp = (i == 12) || r[4];
      va = !((i == 12) || (i > 60 && r[7:5] == 3'h0));
      pg = !((i == 16) || (i > 60 && r[10:8] == 3'h0));
      frame(e0, 1'b1, 1'b1);
    end
    {er, vp, va, pg} = 4'b0011;
    // Long unstable stretch: category 0 run lowers the thresholds
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      frame((i % 2 ? 16'sh3000 : -16'sh3000) + signed'({8'h00, r[7:0]}), 1'b0, i > 0);
    end
    test_done;
  end
endmodule
